// file: rtl/psq_sequencer.sv
// Purpose: program flow sequencer: program counter, return stack, program memory, table reads
// Assumes: decoded instruction stream and interrupt request logic on the pclk domain
// Notes:   one instruction cycle is four pclk cycles; apb answers with one wait state
//
// Summary of operation
// - jumps and calls take two instruction cycles, the second being a dummy.
// - program counter advances by one per fetch unless flow is redirected.
// - software writes only the low eight program counter bits; the status register reads all twelve.
// - jump, call, interrupt and reset load their target straight into the counter.
// - a taken skip discards the prefetched word and runs a dummy cycle.
// - program counter is twelve bits: high nibble and low byte.
// - low byte write jumps inside the current 256-word page.
// - a low byte write inserts one dummy cycle for the new prefetch.
// - eight-entry return stack, its contents and pointer hidden from software.
// - call and interrupt acknowledge push fetch_addr, the address of the prefetched word.
// - both return instructions reload the counter from the stack top.
// - after reset the stack is empty.
// - full stack holds off interrupt acknowledge until a return pops an entry.
// - call on a full stack proceeds and loses the oldest entry.
// - arithmetic results are written back and carry/zero status updated.
// - program memory is 4K words of 16 bits addressed by the counter.
// - reset sets the program counter to address zero.
// - table read sends low byte to data memory, high byte to table high.
// - last-page table read uses F00 plus the low pointer only.
// - every table instruction takes two instruction cycles.
// - four phases per instruction cycle; advance and fetch on the first.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module psq_sequencer
  import psq_pkg::*;
#(
  parameter int unsigned STACK_DEPTH = PSQ_STACK_DEPTH
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // instruction stream
  input  wire psq_cmd_t    cmd,
  output logic      [11:0] fetch_addr,
  output logic      [15:0] exec_word,
  output logic             exec_valid,
  output logic      [1:0]  cycle_phases,
  // interrupt request logic
  input  wire logic        irq_req,
  input  wire logic [11:0] irq_vector,
  output logic             irq_ack,
  // data memory write-back and status
  output psq_wb_t          tbl_wb,
  output psq_wb_t          alu_wb,
  output psq_flags_t       alu_flags
);

  localparam int unsigned      SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
  localparam int unsigned      DC_W = $clog2(STACK_DEPTH + 1);
  localparam logic [DC_W-1:0]  FULL = DC_W'(STACK_DEPTH);
  localparam logic [SP_W-1:0]  LAST = SP_W'(STACK_DEPTH - 1);

  logic [11:0]     pc;
  logic [15:0]     pf;
  logic            pf_valid;
  logic            stall;
  logic            run;
  logic [15:0]     pmem [PSQ_MEM_WORDS];
  logic [11:0]     stk [STACK_DEPTH];
  logic [SP_W-1:0] wp;
  logic [DC_W-1:0] depth;
  logic [7:0]      tblp;
  logic [7:0]      tbhp;
  logic [7:0]      table_data_high;
  logic [11:0]     mem_addr;
  logic            pcl_pend;
  logic [7:0]      pcl_val;
  logic            irq_pend;

  logic            boundary;
  logic            act;
  logic            full;
  logic            take_pcl;
  logic            take_irq;
  logic            norm;
  logic            push;
  logic            pop;
  logic            tbl_go;
  logic            alu_go;
  logic [11:0]     tbl_ptr;
  logic [15:0]     tbl_word;
  logic [11:0]     top;
  logic            wr;
  logic            hit;
  logic [31:0]     rd;

  // decode of the instruction-cycle boundary
  always_comb begin
    boundary = run && (cycle_phases == PSQ_LAST_PHASE);
    act      = boundary && exec_valid;
    full     = (depth == FULL);
    // a pending low byte write outranks both the interrupt and the instruction's own flow
    take_pcl = act && pcl_pend;
    // only non-branching instructions may be followed by an acknowledge
    take_irq = act && !pcl_pend && irq_pend && !full &&
               (cmd.op inside {seq_op, alu_add_op, alu_sub_op});
    norm     = act && !pcl_pend && !take_irq;
    push     = take_irq || (norm && (cmd.op == call_op));
    pop      = norm && (cmd.op inside {subroutine_return_op, interrupt_return_op});
    tbl_go   = norm && (cmd.op inside {table_read_op, ext_table_read_op, last_table_read_op});
    alu_go   = norm && (cmd.op inside {alu_add_op, alu_sub_op});
    if (cmd.op == last_table_read_op) begin
      tbl_ptr = PSQ_LAST_PAGE | {4'h0, tblp};
    end else begin
      tbl_ptr = {tbhp[3:0], tblp};
    end
    tbl_word = pmem[tbl_ptr];
    top      = stk[(wp == '0) ? LAST : wp - 1'b1];
  end

  // phase counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_phases <= PSQ_FETCH_PHASE;
    end else if (run) begin
      cycle_phases <= cycle_phases + 2'h1;
    end
  end

  // fetch pipeline and program counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc         <= PSQ_RESET_VECTOR;
      pf         <= 16'h0000;
      pf_valid   <= 1'b0;
      exec_word  <= 16'h0000;
      exec_valid <= 1'b0;
      fetch_addr <= PSQ_RESET_VECTOR;
      stall      <= 1'b0;
    end else if (run && (cycle_phases == PSQ_FETCH_PHASE)) begin
      if (stall) begin
        // second cycle of a table instruction: nothing moves, no new word executes
        exec_valid <= 1'b0;
        stall      <= 1'b0;
      end else begin
        exec_word  <= pf;
        exec_valid <= pf_valid;
        pf         <= pmem[pc];
        fetch_addr <= pc;
        pf_valid   <= 1'b1;
        pc         <= pc + 12'h001;
      end
    end else if (take_pcl) begin
      pc       <= {pc[11:8], pcl_val};
      pf_valid <= 1'b0;
    end else if (take_irq) begin
      pc       <= irq_vector;
      pf_valid <= 1'b0;
    end else if (norm) begin
      unique case (cmd.op)
        jump_op, call_op: begin
          pc       <= cmd.target;
          pf_valid <= 1'b0;
        end
        subroutine_return_op, interrupt_return_op: begin
          pc       <= top;
          pf_valid <= 1'b0;
        end
        skip_op: begin
          if (cmd.skip_met) begin
            pf_valid <= 1'b0;
          end
        end
        table_read_op, ext_table_read_op, last_table_read_op: begin
          stall <= 1'b1;
        end
        seq_op, alu_add_op, alu_sub_op: begin
        end
        default: begin
        end
      endcase
    end
  end

  // return stack: circular, so a push on a full stack overwrites the oldest entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp    <= '0;
      depth <= '0;
    end else if (push) begin
      wp <= (wp == LAST) ? '0 : wp + 1'b1;
      if (!full) begin
        depth <= depth + 1'b1;
      end
    end else if (pop) begin
      wp <= (wp == '0) ? LAST : wp - 1'b1;
      if (depth != '0) begin
        depth <= depth - 1'b1;
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      stk[wp] <= fetch_addr;
    end
  end

  // interrupt latch: a new request in the acknowledge cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend <= 1'b0;
      irq_ack  <= 1'b0;
    end else begin
      irq_pend <= irq_req || (irq_pend && !take_irq);
      irq_ack  <= take_irq;
    end
  end

  // table read write-back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_wb <= '0;
    end else begin
      tbl_wb.wr <= tbl_go;
      if (tbl_go) begin
        tbl_wb.addr <= cmd.dest;
        tbl_wb.data <= tbl_word[7:0];
      end
    end
  end

  // arithmetic write-back and status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alu_wb    <= '0;
      alu_flags <= '0;
    end else begin
      alu_wb.wr <= alu_go;
      if (alu_go) begin
        alu_wb.addr <= cmd.dest;
        if (cmd.op == alu_sub_op) begin
          alu_wb.data     <= cmd.opa - cmd.opb;
          alu_flags.carry <= (cmd.opa >= cmd.opb);
          alu_flags.zero  <= (cmd.opa == cmd.opb);
        end else begin
          {alu_flags.carry, alu_wb.data} <= {1'b0, cmd.opa} + {1'b0, cmd.opb};
          alu_flags.zero  <= ((cmd.opa + cmd.opb) == 8'h00);
        end
      end
    end
  end

  // apb: one wait state, writes land on the completing edge
  assign wr = psel && penable && pready && pwrite;

  always_comb begin
    hit = 1'b1;
    rd  = 32'h0000_0000;
    case (paddr)
      PSQ_PC_LOW_OFS: rd = {24'h00_0000, pc[7:0]};
      PSQ_TBLP_OFS:   rd = {24'h00_0000, tblp};
      PSQ_TBHP_OFS:   rd = {24'h00_0000, tbhp};
      PSQ_TBL_HI_OFS: rd = {24'h00_0000, table_data_high};
      PSQ_STATUS_OFS: rd = {14'h0000, alu_flags, stall, irq_pend, cycle_phases, pc};
      PSQ_CTRL_OFS:   rd = {31'h0000_0000, run};
      PSQ_MADDR_OFS:  rd = {20'h0_0000, mem_addr};
      PSQ_MDATA_OFS:  rd = {16'h0000, pmem[mem_addr]};
      default:        hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd;
        pslverr <= !hit;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run      <= PSQ_RUN_RESET;
      tblp     <= PSQ_TBL_RESET;
      tbhp     <= PSQ_TBL_RESET;
      mem_addr <= PSQ_MADDR_RESET;
      pcl_pend <= 1'b0;
      pcl_val  <= 8'h00;
    end else begin
      if (wr && (paddr == PSQ_CTRL_OFS)) begin
        run <= pwdata[0];
      end
      if (wr && (paddr == PSQ_TBLP_OFS)) begin
        tblp <= pwdata[7:0];
      end
      if (wr && (paddr == PSQ_TBHP_OFS)) begin
        tbhp <= pwdata[7:0];
      end
      if (wr && (paddr == PSQ_MADDR_OFS)) begin
        mem_addr <= pwdata[11:0];
      end else if (wr && (paddr == PSQ_MDATA_OFS)) begin
        mem_addr <= mem_addr + 12'h001;
      end
      // the jump waits for the next instruction boundary
      if (wr && (paddr == PSQ_PC_LOW_OFS)) begin
        pcl_pend <= 1'b1;
        pcl_val  <= pwdata[7:0];
      end else if (take_pcl) begin
        pcl_pend <= 1'b0;
      end
    end
  end

  // hardware table load wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_data_high <= PSQ_TBL_RESET;
    end else if (tbl_go) begin
      table_data_high <= tbl_word[15:8];
    end else if (wr && (paddr == PSQ_TBL_HI_OFS)) begin
      table_data_high <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk) begin
    if (wr && (paddr == PSQ_MDATA_OFS)) begin
      pmem[mem_addr] <= pwdata[15:0];
    end
  end

  a_phase_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (run && cycle_phases == 2'h3) |=> cycle_phases == 2'h0)
    else $error("phase counter did not wrap after fourth phase");

  a_pc_advance: assert property (@(posedge pclk) disable iff (!presetn)
    (run && cycle_phases == 2'h0 && !stall) |=> pc == $past(pc) + 12'h001)
    else $error("program counter did not advance at fetch");

  a_jump_dummy: assert property (@(posedge pclk) disable iff (!presetn)
    (norm && cmd.op == jump_op && run) |=> (pc == $past(cmd.target)) ##1 !exec_valid)
    else $error("jump did not load target and insert a dummy cycle");

  a_skip_dummy: assert property (@(posedge pclk) disable iff (!presetn)
    (norm && cmd.op == skip_op && cmd.skip_met) |=> !pf_valid && pc == $past(pc))
    else $error("taken skip kept the prefetched word");

  a_pcl_page: assert property (@(posedge pclk) disable iff (!presetn)
    take_pcl |=> (pc[11:8] == $past(pc[11:8]) && pc[7:0] == $past(pcl_val) && !pf_valid))
    else $error("low byte write left its page or skipped the dummy");

  a_push_depth: assert property (@(posedge pclk) disable iff (!presetn)
    (push && !full) |=> depth == $past(depth) + 1'b1)
    else $error("push did not deepen the stack");

  a_overflow_full: assert property (@(posedge pclk) disable iff (!presetn)
    (push && full) |=> full && stk[$past(wp)] == $past(fetch_addr))
    else $error("call on full stack did not overwrite the oldest entry");

  a_ret_restore: assert property (@(posedge pclk) disable iff (!presetn)
    pop |=> pc == $past(top) && !pf_valid)
    else $error("return did not reload the counter from the stack");

  a_full_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (act && irq_pend && full) |=> (!irq_ack && irq_pend))
    else $error("interrupt acknowledged while the stack was full");

  a_tbl_twocycle: assert property (@(posedge pclk) disable iff (!presetn)
    tbl_go |=> (tbl_wb.wr && tbl_wb.addr == $past(cmd.dest) && stall) ##4 !exec_valid)
    else $error("table read did not write back or take two cycles");

  a_reset_state: assert property (@(posedge pclk)
    $rose(presetn) |-> (pc == 12'h000 && depth == '0))
    else $error("reset left counter or stack pointer dirty");

  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb ready not a single-cycle answer");

endmodule

`default_nettype wire

// file: include/psq_pkg.sv
// Purpose: shared constants and carrier types for the program sequencer
// Assumes: 12-bit program addresses, 16-bit program words, 8-bit data path
// Notes:   register offsets are byte addresses on a 32-bit apb bus
`default_nettype none

package psq_pkg;

  // program memory and addressing
  localparam int unsigned    PSQ_MEM_WORDS     = 4096;
  localparam int unsigned    PSQ_STACK_DEPTH   = 8;
  localparam logic [11:0]    PSQ_RESET_VECTOR  = 12'h000;
  localparam logic [11:0]    PSQ_LAST_PAGE     = 12'hf00;

  // instruction cycle phases
  localparam logic [1:0]     PSQ_FETCH_PHASE   = 2'h0;
  localparam logic [1:0]     PSQ_LAST_PHASE    = 2'h3;

  // register byte offsets
  localparam logic [7:0]     PSQ_PC_LOW_OFS    = 8'h00;
  localparam logic [7:0]     PSQ_TBLP_OFS      = 8'h04;
  localparam logic [7:0]     PSQ_TBHP_OFS      = 8'h08;
  localparam logic [7:0]     PSQ_TBL_HI_OFS    = 8'h0c;
  localparam logic [7:0]     PSQ_STATUS_OFS    = 8'h10;
  localparam logic [7:0]     PSQ_CTRL_OFS      = 8'h14;
  localparam logic [7:0]     PSQ_MADDR_OFS     = 8'h18;
  localparam logic [7:0]     PSQ_MDATA_OFS     = 8'h1c;

  // values after reset
  localparam logic [7:0]     PSQ_TBL_RESET     = 8'h00;
  localparam logic [11:0]    PSQ_MADDR_RESET   = 12'h000;
  localparam logic           PSQ_RUN_RESET     = 1'b0;

  typedef enum logic [3:0] {
    seq_op,
    jump_op,
    call_op,
    subroutine_return_op,
    interrupt_return_op,
    skip_op,
    table_read_op,
    ext_table_read_op,
    last_table_read_op,
    alu_add_op,
    alu_sub_op
  } psq_op_t;

  // decoded instruction presented by the core during its execute cycle
  typedef struct packed {
    psq_op_t     op;
    logic [11:0] target;
    logic        skip_met;
    logic [7:0]  dest;
    logic [7:0]  opa;
    logic [7:0]  opb;
  } psq_cmd_t;

  // write-back towards data memory
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  data;
  } psq_wb_t;

  typedef struct packed {
    logic        carry;
    logic        zero;
  } psq_flags_t;

endpackage

`default_nettype wire

// file: testbench/program_sequencer_tb.sv
// Purpose: self-checking bench for the program sequencer
// Assumes: apb slave answers after one wait state; run starts through ctrl
// Notes:   each program word is derived from its own address
`timescale 1ns/1ps
`default_nettype none

module program_sequencer_tb
  import psq_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, exec_valid, irq_req, irq_ack;
  logic [11:0] fetch_addr, irq_vector;
  logic [15:0] exec_word;
  logic [1:0]  cycle_phases;
  psq_cmd_t    cmd;
  psq_wb_t     tbl_wb, alu_wb;
  psq_flags_t  alu_flags;
  int          n_mismatch, samples_checked, cyc;

  psq_sequencer uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd(cmd), .fetch_addr(fetch_addr),
    .exec_word(exec_word), .exec_valid(exec_valid), .cycle_phases(cycle_phases),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .tbl_wb(tbl_wb), .alu_wb(alu_wb), .alu_flags(alu_flags)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic end_sim();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // memory load takes about 16k cycles, the rest well under 10k
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] pw(input logic [11:0] a);
    return {a[3:0] ^ 4'ha, a};
  endfunction

  function automatic psq_cmd_t mk(input psq_op_t o, input logic [11:0] t, input logic s,
                                  input logic [7:0] d, input logic [7:0] a, input logic [7:0] b);
    return '{o, t, s, d, a, b};
  endfunction

  // called just after a rising edge; idle cycle at the end avoids a double drive
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  // samples at the end of phase one, when the fetch results have settled
  task automatic obs(output logic [11:0] fa, output logic [15:0] w, output logic v);
    @(posedge pclk);
    while (cycle_phases !== 2'h1) @(posedge pclk);
    fa = fetch_addr;
    w = exec_word;
    v = exec_valid;
  endtask

  // cmd stands through phase three of a valid cycle, then falls back to idle
  task automatic issue(input psq_cmd_t c, output logic [11:0] ra);
    @(posedge pclk);
    while (!(cycle_phases === 2'h2 && exec_valid === 1'b1)) @(posedge pclk);
    cmd <= c;
    ra = fetch_addr;
    @(posedge pclk);
    cmd <= mk(seq_op, 12'h000, 1'b0, 8'h00, 8'h00, 8'h00);
  endtask

  task automatic land(input logic [11:0] t);
    logic [11:0] fa;
    logic [15:0] w;
    logic        v;
    obs(fa, w, v);
    chk(v, 1'b0);
    obs(fa, w, v);
    chk(v, 1'b1);
    chk(w, pw(t));
  endtask

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    apb(1'b0, PSQ_PC_LOW_OFS, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'b0, PSQ_STATUS_OFS, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
  endtask

  task automatic t_seq();
    logic [11:0] fa, f0;
    logic [15:0] w;
    logic        v;
    time         t0;
    wr(PSQ_CTRL_OFS, 32'h1);
    do obs(f0, w, v); while (v !== 1'b1);
    chk(w, pw(PSQ_RESET_VECTOR));
    for (int i = 0; i < 3; i++) begin
      t0 = $time;
      obs(fa, w, v);
      chk(32'($time - t0), 32'd100);
      chk(fa, f0 + 12'h1);
      chk(w, pw(f0));
      f0 = fa;
    end
  endtask

  task automatic t_flow();
    logic [11:0] ra, fa, f0;
    logic [15:0] w;
    logic [31:0] r;
    logic        v, e, d;
    issue(mk(jump_op, 12'h310, 1'b0, 8'h00, 8'h00, 8'h00), ra);
    land(12'h310);
    issue(mk(skip_op, 12'h000, 1'b1, 8'h00, 8'h00, 8'h00), ra);
    obs(fa, w, v);
    chk(v, 1'b0);
    obs(fa, w, v);
    chk(w, pw(ra + 12'h1));
    issue(mk(skip_op, 12'h000, 1'b0, 8'h00, 8'h00, 8'h00), ra);
    obs(fa, w, v);
    chk({v, w}, {1'b1, pw(ra)});
    // bit 8 of the written value must not reach the page bits
    d = 1'b0;
    wr(PSQ_PC_LOW_OFS, 32'h1c0);
    repeat (6) begin
      obs(fa, w, v);
      if (v === 1'b0) d = 1'b1;
      if (v === 1'b1 && d) break;
    end
    chk(d, 1'b1);
    chk(w, pw(12'h3c0));
    apb(1'b0, PSQ_PC_LOW_OFS, 32'h0, r, e);
    // the counter is still a few words past 3c0, so the low byte reads back as c-something
    chk(r[31:4], 28'h000000c);
    obs(f0, w, v);
    obs(fa, w, v);
    chk({v, fa}, {1'b1, f0 + 12'h1});
  endtask

  task automatic t_table();
    psq_op_t     ops[3] = '{table_read_op, ext_table_read_op, last_table_read_op};
    logic [11:0] tas[3] = '{12'h934, 12'h934, 12'hf34};
    logic [11:0] ra, fa;
    logic [15:0] w, ew;
    logic [31:0] r;
    logic        v, e;
    // irq_req stays low here, as software masks interrupts round table reads
    wr(PSQ_TBLP_OFS, 32'h34);
    wr(PSQ_TBHP_OFS, 32'h09);
    for (int i = 0; i < 3; i++) begin
      ew = pw(tas[i]);
      issue(mk(ops[i], 12'h000, 1'b0, 8'h50 + 8'(i), 8'h00, 8'h00), ra);
      do @(posedge pclk); while (tbl_wb.wr !== 1'b1);
      chk({tbl_wb.addr, tbl_wb.data}, {8'h50 + 8'(i), ew[7:0]});
      obs(fa, w, v);
      chk(v, 1'b0);
      obs(fa, w, v);
      chk(w, pw(ra));
      apb(1'b0, PSQ_TBL_HI_OFS, 32'h0, r, e);
      chk(r, {24'h0, ew[15:8]});
    end
  endtask

  task automatic t_alu();
    psq_op_t    ops[3] = '{alu_add_op, alu_sub_op, alu_sub_op};
    logic [7:0] av[3]  = '{8'hf0, 8'h20, 8'h10};
    logic [7:0] res[3] = '{8'h10, 8'h00, 8'hf0};
    logic [1:0] cz[3]  = '{2'b10, 2'b11, 2'b00};
    logic [11:0] ra;
    for (int i = 0; i < 3; i++) begin
      issue(mk(ops[i], 12'h000, 1'b0, 8'h60, av[i], 8'h20), ra);
      do @(posedge pclk); while (alu_wb.wr !== 1'b1);
      chk({alu_wb.addr, alu_wb.data}, {8'h60, res[i]});
      chk({alu_flags.carry, alu_flags.zero}, cz[i]);
    end
  endtask

  task automatic t_stack();
    logic [11:0] ras[9];
    logic [11:0] ra, fa;
    logic [15:0] w, e0;
    logic        v;
    int          n;
    for (int i = 0; i < 9; i++) begin
      issue(mk(call_op, 12'h500 + 12'(i * 16), 1'b0, 8'h00, 8'h00, 8'h00), ras[i]);
      land(12'h500 + 12'(i * 16));
    end
    // a one-cycle request: the latch must keep it while the stack is full,
    // and a request held past the acknowledge would be taken a second time
    irq_vector <= 12'h800;
    irq_req    <= 1'b1;
    @(posedge pclk);
    irq_req    <= 1'b0;
    n = 0;
    repeat (16) begin
      @(posedge pclk);
      n += int'(irq_ack === 1'b1);
    end
    chk(n, 0);
    issue(mk(subroutine_return_op, 12'h000, 1'b0, 8'h00, 8'h00, 8'h00), ra);
    land(ras[8]);
    n = 0;
    while (irq_ack !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk(irq_ack, 1'b1);
    land(12'h800);
    issue(mk(interrupt_return_op, 12'h000, 1'b0, 8'h00, 8'h00, 8'h00), ra);
    land(ras[8] + 12'h1);
    for (int i = 7; i > 0; i--) begin
      issue(mk(subroutine_return_op, 12'h000, 1'b0, 8'h00, 8'h00, 8'h00), ra);
      land(ras[i]);
    end
    // the first saved address was overwritten by the ninth call
    e0 = pw(ras[0]);
    issue(mk(subroutine_return_op, 12'h000, 1'b0, 8'h00, 8'h00, 8'h00), ra);
    obs(fa, w, v);
    obs(fa, w, v);
    chk(32'(w !== e0), 32'h1);
  endtask

  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    cyc = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    irq_req = 1'b0;
    irq_vector = 12'h000;
    cmd = mk(seq_op, 12'h000, 1'b0, 8'h00, 8'h00, 8'h00);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    wr(PSQ_MADDR_OFS, 32'h0);
    for (int i = 0; i < 4096; i++) begin
      wr(PSQ_MDATA_OFS, {16'h0, pw(12'(i))});
    end
    t_seq();
    t_flow();
    t_table();
    t_alu();
    t_stack();
    end_sim();
  end
endmodule

`default_nettype wire
